// file: spbsp_top.sv
// Overview of operation
// - Every synchronous input is captured in an input register at clock rise.
// - Read data leaves through an output register, so reads are pipelined.
// - A 2-bit burst counter loads the start and wraps within four words.
// - The two lowest address bits load the burst counter on address capture.
// - The burst-order strap picks interleaved or linear stepping.
// - The 15-bit address is taken only with a strobe and all enables active.
// - The burst counter steps only while the advance input is low.
// - The processor strobe is ignored while the first chip select is high.
// - The first chip select is active low and joins device selection.
// - The second chip select is active high and joins device selection.
// - A low global write writes all four bytes, ignoring byte controls.
// - A byte is written when its select and the byte write enable are low.
// - Writes complete internally from registered inputs, no write pulse.
// - The asynchronous output enable gates the data pin drivers together with a registered read-valid flag.
// - Output enable is masked in the first read clock after deselect.
// - Words are 32 bits on one shared bidirectional data bus.
// - With both strobes low the processor strobe wins while the first chip select is low; otherwise the controller strobe is acted on.
// - Strap low gives linear order, high gives interleaved; it stays static.
// - The third chip select is active low and joins device selection.
// - Read data belong to the address registered at the previous rise.
`timescale 1ns/1ps
`default_nettype none

module spbsp_top #(
    parameter int ADDR_W = spbsp_pkg::ADDR_W,
    parameter int DATA_W = spbsp_pkg::DATA_W
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Address and strobes
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic PROC_ADDR_STROBE_N_IN,
    input wire logic CTRL_ADDR_STROBE_N_IN,
    input wire logic BURST_ADVANCE_N_IN,
    // Write controls
    input wire logic [spbsp_pkg::LANES-1:0] BYTE_SEL_N_IN,
    input wire logic BYTE_WR_EN_N_IN,
    input wire logic GLOBAL_WR_N_IN,
    // Chip selects
    input wire logic CHIP_SEL_A_N_IN,
    input wire logic CHIP_SEL_B_IN,
    input wire logic CHIP_SEL_C_N_IN,
    // Output enable and burst strap
    input wire logic OUT_EN_N_IN,
    input wire logic BURST_MODE_IN,
    // Shared data bus, split into its three signals
    input wire logic [DATA_W-1:0] DQ_IN,
    output logic [DATA_W-1:0] DQ_OUT,
    output logic DQ_OE_OUT
);
    import spbsp_pkg::*;

    // ************************************************************
    // Functions
    // ************************************************************
    // Interleaved steps by XOR, linear by wrapping add
    function automatic logic [BURST_W-1:0] burst_lsb(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] count,
        input logic linear
    );
        logic [BURST_W-1:0] res;
        res = start ^ count;
        if (linear) begin
            res = start + count;
        end
        return res;
    endfunction

    // Global write beats every byte control
    function automatic logic [LANES-1:0] lane_writes(
        input logic gw_n,
        input logic bwe_n,
        input logic [LANES-1:0] bs_n
    );
        logic [LANES-1:0] res;
        res = LANES_NONE;
        if (!gw_n) begin
            res = LANES_ALL;
        end else if (!bwe_n) begin
            res = ~bs_n;
        end
        return res;
    endfunction

    // ************************************************************
    // Input register
    // ************************************************************
    logic [ADDR_W-1:0] in_addr;
    logic in_pstb_n;
    logic in_cstb_n;
    logic in_adv_n;
    logic [LANES-1:0] in_bsel_n;
    logic in_bwe_n;
    logic in_gw_n;
    logic in_cs_a_n;
    logic in_cs_b;
    logic in_cs_c_n;
    logic [DATA_W-1:0] in_data;

    // Master shares this clock, so one register stage is all it needs
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            in_addr <= ADDR_RST;
            in_pstb_n <= STROBE_IDLE_N;
            in_cstb_n <= STROBE_IDLE_N;
            in_adv_n <= STROBE_IDLE_N;
        end else begin
            in_addr <= ADDR_IN;
            in_pstb_n <= PROC_ADDR_STROBE_N_IN;
            in_cstb_n <= CTRL_ADDR_STROBE_N_IN;
            in_adv_n <= BURST_ADVANCE_N_IN;
        end
    end

    // ************************************************************
    // Input register: write controls and data
    // ************************************************************
    // Idle levels ask for no write, so reset never touches a word
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            in_bsel_n <= LANES_OFF_N;
            in_bwe_n <= STROBE_IDLE_N;
            in_gw_n <= STROBE_IDLE_N;
        end else begin
            in_bsel_n <= BYTE_SEL_N_IN;
            in_bwe_n <= BYTE_WR_EN_N_IN;
            in_gw_n <= GLOBAL_WR_N_IN;
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            in_data <= DATA_RST;
        end else begin
            in_data <= DQ_IN;
        end
    end

    // ************************************************************
    // Input register: chip selects
    // ************************************************************
    // Reset levels leave the bank deselected
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            in_cs_a_n <= STROBE_IDLE_N;
            in_cs_b <= 1'b0;
            in_cs_c_n <= STROBE_IDLE_N;
        end else begin
            in_cs_a_n <= CHIP_SEL_A_N_IN;
            in_cs_b <= CHIP_SEL_B_IN;
            in_cs_c_n <= CHIP_SEL_C_N_IN;
        end
    end

    // ************************************************************
    // Burst order strap
    // ************************************************************
    logic mode_meta;
    logic mode_sync;
    logic mode_linear;

    // Strap is a free pin, so it is synchronised before use
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            mode_meta <= MODE_RST;
            mode_sync <= MODE_RST;
        end else begin
            mode_meta <= BURST_MODE_IN;
            mode_sync <= mode_meta;
        end
    end

    // Low selects linear; a floating pin reads high, so interleaved
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            mode_linear <= 1'b0;
        end else begin
            mode_linear <= ~mode_sync;
        end
    end

    // ************************************************************
    // Access decode
    // ************************************************************
    spbsp_state_e state;
    spbsp_state_e next_state;
    logic [ADDR_W-ROW_LSB-1:0] row;
    logic [BURST_W-1:0] start_lsb;
    logic [BURST_W-1:0] count;
    logic [BURST_W-1:0] next_count;
    logic selected;
    logic proc_take;
    logic ctrl_take;
    logic take;
    logic begin_acc;
    logic go_idle;
    logic keep_acc;
    logic [LANES-1:0] lanes;

    // A bank is chosen only when all three selects agree
    always_comb begin
        selected = ~in_cs_a_n & in_cs_b & ~in_cs_c_n;
    end

    // Processor strobe needs the first select and wins a tie
    always_comb begin
        proc_take = ~in_pstb_n & ~in_cs_a_n;
        ctrl_take = ~in_cstb_n & ~proc_take;
        take = proc_take | ctrl_take;
    end

    always_comb begin
        begin_acc = take & selected;
        go_idle = take & ~selected;
        keep_acc = ~take && (state == ST_ACTIVE);
        lanes = lane_writes(in_gw_n, in_bwe_n, in_bsel_n);
    end

    // ************************************************************
    // Access state
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_DESELECTED: begin
                if (begin_acc) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (go_idle) begin
                    next_state = ST_DESELECTED;
                end
            end
            default: begin
                next_state = ST_DESELECTED;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            state <= ST_DESELECTED;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Address register
    // ************************************************************
    // Row and start stay put for the whole burst; only the count moves
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            row <= ADDR_RST[ADDR_W-1:ROW_LSB];
            start_lsb <= COUNT_RST;
        end else if (begin_acc) begin
            row <= in_addr[ADDR_W-1:ROW_LSB];
            start_lsb <= in_addr[BURST_LSB +: BURST_W];
        end
    end

    // ************************************************************
    // Burst counter
    // ************************************************************
    always_comb begin
        next_count = count;
        if (keep_acc && !in_adv_n) begin
            next_count = count + COUNT_STEP;
        end
    end

    // Wraps by width alone, so a fourth advance restarts the group
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            count <= COUNT_RST;
        end else if (begin_acc) begin
            count <= COUNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // ************************************************************
    // Array port
    // ************************************************************
    spbsp_mem_if #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .LANES(LANES)
    ) mem_bus ();

    // New address goes straight to the array so data follow one rise later
    always_comb begin
        mem_bus.en = begin_acc | keep_acc;
        mem_bus.we = lanes;
        mem_bus.wdata = in_data;
        if (begin_acc) begin
            mem_bus.addr = in_addr;
        end else begin
            mem_bus.addr = {row, burst_lsb(start_lsb, next_count, mode_linear)};
        end
    end

    spbsp_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .BYTE_W(BYTE_W)
    ) i_spbsp_mem (
        .clk_in(CLK_SYS_IN),
        .rst_in(RST_IN),
        .port(mem_bus.array)
    );

    // ************************************************************
    // Output stage
    // ************************************************************
    logic rd_valid;

    // Marks that the output register holds data of a real read
    always_ff @(posedge CLK_SYS_IN) begin
        if (RST_IN) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= mem_bus.en && (mem_bus.we == LANES_NONE);
        end
    end

    assign DQ_OUT = mem_bus.rdata;

    // ************************************************************
    // Output enable
    // ************************************************************
    // Enable path is deliberately combinational: the pin is asynchronous.
    // Without a valid read behind it the enable stays masked, which keeps
    // a bank that just woke from deselect off a shared bus.
    assign DQ_OE_OUT = ~OUT_EN_N_IN & rd_valid;

endmodule

`default_nettype wire

// file: spbsp_pkg.sv
`default_nettype none

package spbsp_pkg;

    // ************************************************************
    // Array geometry
    // ************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int LANES = DATA_W / BYTE_W;
    localparam int DEPTH = 1 << ADDR_W;

    // ************************************************************
    // Burst counter layout
    // ************************************************************
    localparam int BURST_W = 2;
    localparam int BURST_LSB = 0;
    localparam int ROW_LSB = BURST_W;

    // ************************************************************
    // Reset values, lane patterns and the count step
    // ************************************************************
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    localparam logic [LANES-1:0] LANES_OFF_N = 4'hf;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hf;
    localparam logic [BURST_W-1:0] COUNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] COUNT_STEP = 2'h1;
    localparam logic STROBE_IDLE_N = 1'b1;
    localparam logic MODE_RST = 1'b1;

    // ************************************************************
    // Access state
    // ************************************************************
    typedef enum logic {
        ST_DESELECTED,
        ST_ACTIVE
    } spbsp_state_e;

endpackage

`default_nettype wire

// file: spbsp_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface spbsp_mem_if #(
    parameter int ADDR_W = spbsp_pkg::ADDR_W,
    parameter int DATA_W = spbsp_pkg::DATA_W,
    parameter int LANES = spbsp_pkg::LANES
);
    logic en;
    logic [LANES-1:0] we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport ctrl (
        output en,
        output we,
        output addr,
        output wdata,
        input rdata
    );

    modport array (
        input en,
        input we,
        input addr,
        input wdata,
        output rdata
    );
endinterface

`default_nettype wire

// file: spbsp_mem.sv
`timescale 1ns/1ps
`default_nettype none

module spbsp_mem #(
    parameter int ADDR_W = spbsp_pkg::ADDR_W,
    parameter int DATA_W = spbsp_pkg::DATA_W,
    parameter int BYTE_W = spbsp_pkg::BYTE_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Access port
    spbsp_mem_if.array port
);
    import spbsp_pkg::*;

    localparam int NLANE = DATA_W / BYTE_W;
    localparam int NWORD = 1 << ADDR_W;

    logic [DATA_W-1:0] store [NWORD];

    // ************************************************************
    // Self-timed write, all enabled lanes on the same rise
    // ************************************************************
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < NLANE; i++) begin
            if (port.en && port.we[i]) begin
                store[port.addr][i*BYTE_W +: BYTE_W] <= port.wdata[i*BYTE_W +: BYTE_W];
            end
        end
    end

    // ************************************************************
    // Output register
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            port.rdata <= DATA_RST;
        end else if (port.en && (port.we == LANES_NONE)) begin
            port.rdata <= store[port.addr];
        end
    end

endmodule

`default_nettype wire

// file: spbsp_host.sv
`timescale 1ns/1ps
`default_nettype none

module spbsp_host (
    // Clock
    input wire logic clk_in,
    // Device side of the bus
    input wire logic [spbsp_pkg::DATA_W-1:0] dev_q_in,
    input wire logic dev_oe_in,
    // Master side of the bus
    input wire logic drive_in,
    input wire logic [spbsp_pkg::DATA_W-1:0] data_in,
    output logic [spbsp_pkg::DATA_W-1:0] bus_out
);
    import spbsp_pkg::*;
    // ************
    // Bus level
    // ************
    logic [DATA_W-1:0] last;
    always_ff @(posedge clk_in) begin
        last <= bus_out;
    end
    // Released bus flips, so stale data never looks valid
    assign bus_out = dev_oe_in ? dev_q_in : drive_in ? data_in : ~last;
endmodule

`default_nettype wire

// file: spbsp_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module spbsp_props #(
    parameter int ADDR_W = spbsp_pkg::ADDR_W,
    parameter int DATA_W = spbsp_pkg::DATA_W
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Controls
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic PROC_ADDR_STROBE_N_IN,
    input wire logic CTRL_ADDR_STROBE_N_IN,
    input wire logic BURST_ADVANCE_N_IN,
    input wire logic [spbsp_pkg::LANES-1:0] BYTE_SEL_N_IN,
    input wire logic BYTE_WR_EN_N_IN,
    input wire logic GLOBAL_WR_N_IN,
    input wire logic CHIP_SEL_A_N_IN,
    input wire logic CHIP_SEL_B_IN,
    input wire logic CHIP_SEL_C_N_IN,
    input wire logic OUT_EN_N_IN,
    input wire logic BURST_MODE_IN,
    // Data bus
    input wire logic [DATA_W-1:0] DQ_IN,
    input wire logic [DATA_W-1:0] DQ_OUT,
    input wire logic DQ_OE_OUT
);
    import spbsp_pkg::*;
    // ************
    // Decode
    // ************
    wire logic sel = !CHIP_SEL_A_N_IN && CHIP_SEL_B_IN && !CHIP_SEL_C_N_IN;
    wire logic stb = !PROC_ADDR_STROBE_N_IN && !CHIP_SEL_A_N_IN || !CTRL_ADDR_STROBE_N_IN;
    wire logic nowr = GLOBAL_WR_N_IN && BYTE_WR_EN_N_IN;
    wire logic start = stb && sel;
    wire logic desel = stb && !sel;
    wire logic rd = start && nowr;
    wire logic gw = start && !GLOBAL_WR_N_IN;
    wire logic bw0 = start && GLOBAL_WR_N_IN && !BYTE_WR_EN_N_IN && BYTE_SEL_N_IN == 4'he;
    wire logic skip = !PROC_ADDR_STROBE_N_IN && CHIP_SEL_A_N_IN && CTRL_ADDR_STROBE_N_IN;
    wire logic hold = !stb && !skip && BURST_ADVANCE_N_IN && nowr;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    oe_async_a: assert property (DQ_OE_OUT |-> !OUT_EN_N_IN)
        else $error("bus driven with enable high");
    desel_quiet_a: assert property (desel |-> ##2 !DQ_OE_OUT)
        else $error("deselected bank drove bus");
    first_mask_a: assert property (desel ##1 rd |=> !DQ_OE_OUT ##1 DQ_OE_OUT == !OUT_EN_N_IN)
        else $error("first read clock not masked");
    read_drive_a: assert property (rd |-> ##2 DQ_OE_OUT == !OUT_EN_N_IN)
        else $error("read data not driven in time");
    wr_quiet_a: assert property (gw |-> ##2 !DQ_OE_OUT)
        else $error("bus driven after write");
    gw_data_a: assert property (rd && $past(gw) && ADDR_IN == $past(ADDR_IN)
        |-> ##2 DQ_OUT == $past(DQ_IN, 3))
        else $error("global write data lost");
    byte_data_a: assert property (rd && $past(bw0) && ADDR_IN == $past(ADDR_IN)
        |-> ##2 DQ_OUT[7:0] == $past(DQ_IN[7:0], 3))
        else $error("byte write data lost");
    ignore_proc_a: assert property (desel ##1 skip |-> ##2 !DQ_OE_OUT)
        else $error("processor strobe not ignored");
    hold_addr_a: assert property (rd ##1 hold |-> ##2 $stable(DQ_OUT))
        else $error("address moved without advance");
endmodule

bind spbsp_top spbsp_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_spbsp_props (
    .CLK_SYS_IN, .RST_IN, .ADDR_IN, .PROC_ADDR_STROBE_N_IN, .CTRL_ADDR_STROBE_N_IN,
    .BURST_ADVANCE_N_IN, .BYTE_SEL_N_IN, .BYTE_WR_EN_N_IN, .GLOBAL_WR_N_IN,
    .CHIP_SEL_A_N_IN, .CHIP_SEL_B_IN, .CHIP_SEL_C_N_IN, .OUT_EN_N_IN, .BURST_MODE_IN,
    .DQ_IN, .DQ_OUT, .DQ_OE_OUT);

`default_nettype wire

// file: test_spbsp_top.sv
`timescale 1ns/1ps
`default_nettype none

module test_spbsp_top;
    import spbsp_pkg::*;
    // ************
    // Pins and model
    // ************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = 15'h0000;
    logic ps_n = 1'b1, cs_n = 1'b1, adv_n = 1'b1, gw_n = 1'b1, bwe_n = 1'b1;
    logic [LANES-1:0] bs_n = 4'hf;
    logic sa_n = 1'b1, sb = 1'b0, sc_n = 1'b1, oe_n = 1'b1, mode = 1'b1, hd = 1'b0;
    logic [DATA_W-1:0] hdata = 32'h0000_0000;
    wire logic [DATA_W-1:0] dq_in;
    wire logic [DATA_W-1:0] dq_out;
    wire logic dq_oe;
    bit [31:0] mem[int];
    bit [31:0] ed[int];
    bit er[int];
    int n = 0, tmo = 0, fails = 0, checked = 0, seed = 29;
    int base = 0, cnt = 0, act = 0, oe_r = 0;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        n <= n + 1;
        tmo <= tmo + 1;
        if (tmo == 3000) begin
            fails++;
            final_report();
        end
    end
    spbsp_top i_spbsp_top (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
        .PROC_ADDR_STROBE_N_IN(ps_n), .CTRL_ADDR_STROBE_N_IN(cs_n),
        .BURST_ADVANCE_N_IN(adv_n), .BYTE_SEL_N_IN(bs_n), .BYTE_WR_EN_N_IN(bwe_n),
        .GLOBAL_WR_N_IN(gw_n), .CHIP_SEL_A_N_IN(sa_n), .CHIP_SEL_B_IN(sb),
        .CHIP_SEL_C_N_IN(sc_n), .OUT_EN_N_IN(oe_n), .BURST_MODE_IN(mode),
        .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe));
    spbsp_host i_spbsp_host (.clk_in(clk), .dev_q_in(dq_out), .dev_oe_in(dq_oe),
        .drive_in(hd), .data_in(hdata), .bus_out(dq_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One bus cycle, applied at the falling edge; results land two rises later
    task automatic cyc(input bit p, c, v, g, w, input bit [3:0] b, input bit [2:0] s,
                       input int a);
        bit [31:0] m;
        bit [31:0] d;
        int ad;
        bit wr;
        d = $random(seed);
        wr = !g || !w;
        if (er.exists(n)) begin
            chk(dq_oe, er[n] && !oe_n);
            if (er[n]) chk(dq_out, ed[n]);
        end
        {ps_n, cs_n, adv_n, gw_n, bwe_n, bs_n} = {p, c, v, g, w, b};
        {sa_n, sb, sc_n} = s;
        addr = a[ADDR_W-1:0];
        hd = wr;
        hdata = d;
        oe_n = wr || oe_r[0];
        if ((!p && !s[2]) || !c) begin
            act = (s == 3'b010);
            base = a;
            cnt = 0;
        end else if (act != 0 && !v) begin
            cnt++;
        end
        ad = (base & ~3) | ((mode ? base ^ cnt : base + cnt) & 3);
        m = mem.exists(ad) ? mem[ad] : 0;
        for (int i = 0; i < 4; i++) begin
            if (!g || !b[i] && !w) m[8*i +: 8] = d[8*i +: 8];
        end
        if (act != 0 && wr) mem[ad] = m;
        er[n + 2] = act != 0 && !wr;
        ed[n + 2] = m;
        @(negedge clk);
    endtask
    task automatic reset_dut();
        {ps_n, cs_n, gw_n, bwe_n, hd} = 5'h1e;
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        act = 0;
        er.delete();
        // Strap settles three edges after release
        repeat (3) @(negedge clk);
    endtask
    initial begin
        int r;
        for (int md = 1; md >= 0; md--) begin
            mode = md[0];
            oe_r = 0;
            reset_dut();
            for (int a = 0; a < 16; a++) cyc(0, 1, 1, 0, 1, 4'hf, 3'b010, a);
            cyc(1, 0, 1, 1, 1, 4'h0, 3'b010, 13);
            repeat (5) cyc(1, 1, 0, 1, 1, 4'h0, 3'b010, 0);
            for (int j = 0; j < 3; j++) begin
                cyc(1, 0, 1, 1, 1, 4'hf, 3'b010 ^ (3'b001 << j), 2);
                cyc(0, 0, 1, 1, 1, 4'hf, 3'b010, 6);
                cyc(1, 0, 1, 1, 1, 4'hf, 3'b010 ^ (3'b001 << j), 7);
                cyc(0, 1, 1, 1, 1, 4'hf, 3'b110, 9);
                cyc(0, 1, 1, 1, 0, 4'he, 3'b010, 9);
                cyc(0, 1, 1, 1, 1, 4'h0, 3'b010, 9);
                cyc(1, 0, 1, 0, 0, 4'hf, 3'b010, 3);
                cyc(1, 0, 1, 1, 1, 4'hf, 3'b010, 3);
                cyc(1, 1, 1, 1, 1, 4'hf, 3'b010, 0);
            end
            for (int k = 0; k < 150; k++) begin
                r = $random(seed);
                oe_r = r[24] & r[25];
                cyc(r[0] | r[1], r[2] | r[3], r[4], r[5] | r[6] | r[7], r[8] | r[9],
                    (r[9:8] == 0 && r[13:10] == 4'hf) ? 4'he : r[13:10],
                    (r[17:15] == 0) ? r[20:18] : 3'b010, r[23:20]);
            end
            repeat (2) cyc(1, 1, 1, 1, 1, 4'hf, 3'b010, 0);
        end
        final_report();
    end
endmodule

`default_nettype wire
